// File: rtl/stdc_cfg.svh
// Addresses, field positions, reset values and timing counts of the tick counter
`ifndef STDC_CFG_SVH
`define STDC_CFG_SVH

// ==========================================================
// Register addresses in the system control space
`define STDC_CSR_ADDR 32'hE000E010
`define STDC_RVR_ADDR 32'hE000E014
`define STDC_CVR_ADDR 32'hE000E018
`define STDC_CAL_ADDR 32'hE000E01C

// ==========================================================
// Field positions
`define STDC_BIT_ENABLE 0
`define STDC_BIT_TICK_EN 1
`define STDC_BIT_CLK_SEL 2
`define STDC_BIT_WRAP 16
`define STDC_BIT_NO_REF 31
`define STDC_BIT_SKEW 30

// ==========================================================
// Widths and reset values
`define STDC_CNT_W 24
`define STDC_CNT_ZERO 24'h000000
`define STDC_CNT_ONE 24'h000001
`define STDC_CSR_RESET 3'h0
`define STDC_WORD_ZERO 32'h00000000

// ==========================================================
// Timing: core clock rate and the calibration period
`define STDC_CLK_HZ 20000000
`define STDC_CAL_TIME_MS 10
`define STDC_TEN_MS_CYC ((`STDC_CAL_TIME_MS * `STDC_CLK_HZ) / 1000 - 1)

`endif

// File: rtl/stdc_pkg.sv
// Types shared by the tick counter modules
package stdc_pkg;

	// ==========================================================
	// Register access request, one per cycle
	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} stdc_req_t;

	// ==========================================================
	// Stored control fields
	typedef struct packed {
		logic clk_sel;
		logic tick_en;
		logic enable;
	} stdc_csr_t;

endpackage

// File: rtl/stdc_ref_sync.sv
// Synchroniser and rising-edge detector for the external reference clock
`timescale 1ns/1ps
module stdc_ref_sync (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ref_in,
	output logic rise_out
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	// ==========================================================
	// Two-stage synchroniser; only the second stage feeds the detector
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= ref_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign rise_out = sync_q & ~last_q;
endmodule

// File: rtl/stdc_top.sv
// 24-bit self-reloading system tick down-counter with its four registers
// How it works
// - 24-bit down-counter, reloads at zero, any current-value write clears it.
// - While enabled, count down; edge after zero loads reload, then keep counting.
// - Reload value of zero leaves the counter parked at zero after wrap.
// - Wrap flag, control bit 16, sets on a one-to-zero step.
// - Reading the control register returns the flag, then clears it.
// - Writing the current-value register clears counter and wrap flag.
// - That clearing write never pends the tick exception.
// - Current-value read returns the counter as it stands at access.
// - Debug halt freezes the counter.
// - Control bit 2 selects clock: zero reference, one core clock.
// - Without reference clock, clock select reads one and ignores writes.
// - Control bit 1 set: counting down to zero pends the tick exception.
// - Control bit 0 enables repeated counting with reload at every wrap.
// - Reload register holds 24 bits; bits 31 to 24 read zero.
// - Read-only calibration register gives the reload for a 10 ms period.
// - Reference clock is synchronised to the core clock before use.
// - Calibration bit 31 flags no reference, bit 30 inexact; zero means unknown.
`timescale 1ns/1ps
`include "stdc_cfg.svh"
module stdc_top #(
	parameter logic REF_PRESENT = 1'b1,
	parameter logic CAL_SKEW = 1'b0,
	parameter logic [23:0] CAL_TEN_MS = 24'(`STDC_TEN_MS_CYC)
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire stdc_pkg::stdc_req_t req_in,
	input wire logic ref_clk_in,
	input wire logic debug_halt_in,
	output logic [31:0] rdata_out,
	output logic rvalid_out,
	output logic tick_pend_out
);

	// ==========================================================
	// State
	stdc_pkg::stdc_csr_t csr_q;
	logic [23:0] reload_q;
	logic [23:0] cnt_q;
	logic [23:0] cnt_d;
	logic wrap_q;
	logic wrap_d;
	logic pend_q;
	logic [31:0] rdata_q;
	logic rvalid_q;

	// ==========================================================
	// Address decode
	wire csr_hit = (req_in.addr == `STDC_CSR_ADDR);
	wire rvr_hit = (req_in.addr == `STDC_RVR_ADDR);
	wire cvr_hit = (req_in.addr == `STDC_CVR_ADDR);
	wire cal_hit = (req_in.addr == `STDC_CAL_ADDR);
	wire wr_req = req_in.valid & req_in.write;
	wire rd_req = req_in.valid & ~req_in.write;
	wire csr_wr = wr_req & csr_hit;
	wire rvr_wr = wr_req & rvr_hit;
	// Calibration is read-only, so a write there is simply dropped
	wire cvr_wr = wr_req & cvr_hit;
	wire csr_rd = rd_req & csr_hit;

	// ==========================================================
	// Counting clock selection
	logic ref_rise;

	stdc_ref_sync stdc_ref_sync_inst (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.ref_in(ref_clk_in),
		.rise_out(ref_rise)
	);

	// Forced to core clock when no reference exists
	wire clk_sel_rd = csr_q.clk_sel | ~REF_PRESENT;
	// Reference steps only on its synchronised rising edge
	wire tick_src = clk_sel_rd | (REF_PRESENT & ref_rise);

	// ==========================================================
	// Counter next value
	// A clearing write overrides counting in the same cycle
	wire cnt_tick = csr_q.enable & ~debug_halt_in & tick_src & ~cvr_wr;
	wire cnt_zero = (cnt_q == `STDC_CNT_ZERO);
	wire step = cnt_tick & (cnt_q == `STDC_CNT_ONE);

	// Zero reload keeps the counter parked at zero
	assign cnt_d = cvr_wr ? `STDC_CNT_ZERO :
		~cnt_tick ? cnt_q :
		cnt_zero ? reload_q :
		cnt_q - `STDC_CNT_ONE;

	// A new wrap beats a read clear so no event is lost
	assign wrap_d = step | (wrap_q & ~(csr_rd | cvr_wr));

	// ==========================================================
	// Read data
	wire [31:0] csr_word = {15'h0000, wrap_q, 13'h0000, clk_sel_rd, csr_q.tick_en,
		csr_q.enable};
	wire [31:0] rvr_word = {8'h00, reload_q};
	wire [31:0] cvr_word = {8'h00, cnt_q};
	wire [31:0] cal_word = {~REF_PRESENT, CAL_SKEW, 6'h00, CAL_TEN_MS};
	wire [31:0] rd_word = csr_hit ? csr_word :
		rvr_hit ? rvr_word :
		cvr_hit ? cvr_word :
		cal_hit ? cal_word :
		`STDC_WORD_ZERO;

	// ==========================================================
	// Control register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			csr_q <= stdc_pkg::stdc_csr_t'(`STDC_CSR_RESET);
		end else if (csr_wr) begin
			csr_q.enable <= req_in.wdata[`STDC_BIT_ENABLE];
			csr_q.tick_en <= req_in.wdata[`STDC_BIT_TICK_EN];
			csr_q.clk_sel <= req_in.wdata[`STDC_BIT_CLK_SEL] | ~REF_PRESENT;
		end
	end

	// ==========================================================
	// Reload register; upper byte is never stored
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			reload_q <= `STDC_CNT_ZERO;
		end else if (rvr_wr) begin
			reload_q <= req_in.wdata[23:0];
		end
	end

	// ==========================================================
	// Counter, wrap flag and tick pend
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= `STDC_CNT_ZERO;
			wrap_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			wrap_q <= wrap_d;
			// step is never true on a clearing write
			pend_q <= step & csr_q.tick_en;
		end
	end

	// ==========================================================
	// Read answer, one cycle after the request
	// Flag clear and the sampled word share one edge, so the old flag is returned
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_q <= `STDC_WORD_ZERO;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q <= rd_req ? rd_word : `STDC_WORD_ZERO;
			rvalid_q <= rd_req;
		end
	end

	assign rdata_out = rdata_q;
	assign rvalid_out = rvalid_q;
	assign tick_pend_out = pend_q;

	// ==========================================================
	// Assertions

	property p_cvr_clear;
		@(posedge clk_in) disable iff (rst_in)
		cvr_wr |=> (cnt_q == `STDC_CNT_ZERO) && !wrap_q;
	endproperty
	a_cvr_clear: assert property (p_cvr_clear)
		else $error("current-value write did not clear counter and flag");

	property p_decrement;
		@(posedge clk_in) disable iff (rst_in)
		(cnt_tick && !cnt_zero) |=> (cnt_q == $past(cnt_q) - `STDC_CNT_ONE);
	endproperty
	a_decrement: assert property (p_decrement)
		else $error("counter did not decrement by one");

	property p_reload;
		@(posedge clk_in) disable iff (rst_in)
		(cnt_tick && cnt_zero) |=> (cnt_q == $past(reload_q));
	endproperty
	a_reload: assert property (p_reload)
		else $error("counter did not reload at zero");

	property p_park_zero;
		@(posedge clk_in) disable iff (rst_in)
		(cnt_zero && reload_q == `STDC_CNT_ZERO) |=> cnt_zero;
	endproperty
	a_park_zero: assert property (p_park_zero)
		else $error("counter left zero with zero reload");

	property p_wrap_set;
		@(posedge clk_in) disable iff (rst_in)
		(cnt_tick && cnt_q == `STDC_CNT_ONE) |=> wrap_q && cnt_zero;
	endproperty
	a_wrap_set: assert property (p_wrap_set)
		else $error("one-to-zero step did not set wrap flag");

	property p_csr_read;
		@(posedge clk_in) disable iff (rst_in)
		(csr_rd && !step) |=> rvalid_q && (rdata_q[`STDC_BIT_WRAP] == $past(wrap_q))
			&& !wrap_q;
	endproperty
	a_csr_read: assert property (p_csr_read)
		else $error("control read did not return then clear wrap flag");

	property p_no_pend_on_clear;
		@(posedge clk_in) disable iff (rst_in)
		cvr_wr |=> !tick_pend_out;
	endproperty
	a_no_pend_on_clear: assert property (p_no_pend_on_clear)
		else $error("clearing write pended the tick exception");

	property p_halt_hold;
		@(posedge clk_in) disable iff (rst_in)
		(debug_halt_in && !cvr_wr) |=> $stable(cnt_q);
	endproperty
	a_halt_hold: assert property (p_halt_hold)
		else $error("counter moved while halted");

	property p_no_reference_clock_select;
		@(posedge clk_in) disable iff (rst_in)
		!REF_PRESENT |-> clk_sel_rd && tick_src;
	endproperty
	a_no_reference_clock_select: assert property (p_no_reference_clock_select)
		else $error("clock select not forced to core clock");

	property p_pend_pulse;
		@(posedge clk_in) disable iff (rst_in)
		(step && csr_q.tick_en) |=> tick_pend_out ##1 !tick_pend_out;
	endproperty
	a_pend_pulse: assert property (p_pend_pulse)
		else $error("tick pend missing or longer than one cycle");

	property p_pend_cause;
		@(posedge clk_in) disable iff (rst_in)
		$rose(tick_pend_out) |-> $past(csr_q.tick_en) && $past(cnt_q) == `STDC_CNT_ONE;
	endproperty
	a_pend_cause: assert property (p_pend_cause)
		else $error("tick pend without a countdown to zero");

	property p_disabled_hold;
		@(posedge clk_in) disable iff (rst_in)
		(!csr_q.enable && !cvr_wr) |=> $stable(cnt_q);
	endproperty
	a_disabled_hold: assert property (p_disabled_hold)
		else $error("counter moved while disabled");

	property p_rvr_upper;
		@(posedge clk_in) disable iff (rst_in)
		(rd_req && rvr_hit) |=> rdata_q[31:24] == 8'h00;
	endproperty
	a_rvr_upper: assert property (p_rvr_upper)
		else $error("reload upper bits not zero");

	property p_cvr_read;
		@(posedge clk_in) disable iff (rst_in)
		(rd_req && cvr_hit) |=> rdata_q[23:0] == $past(cnt_q);
	endproperty
	a_cvr_read: assert property (p_cvr_read)
		else $error("current-value read mismatch");

	property p_ref_only_edge;
		@(posedge clk_in) disable iff (rst_in)
		(REF_PRESENT && !csr_q.clk_sel && !ref_rise && !cvr_wr) |=> $stable(cnt_q);
	endproperty
	a_ref_only_edge: assert property (p_ref_only_edge)
		else $error("counter moved without reference edge");

	property p_read_answer;
		@(posedge clk_in) disable iff (rst_in)
		rd_req |=> rvalid_out;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read request got no answer");

	property p_no_answer;
		@(posedge clk_in) disable iff (rst_in)
		!rd_req |=> !rvalid_out && (rdata_out == `STDC_WORD_ZERO);
	endproperty
	a_no_answer: assert property (p_no_answer)
		else $error("answer or data without a read");

	property p_csr_reserved;
		@(posedge clk_in) disable iff (rst_in)
		(rd_req && csr_hit) |=> (rdata_q[31:17] == 15'h0000) && (rdata_q[15:3] == 13'h0000);
	endproperty
	a_csr_reserved: assert property (p_csr_reserved)
		else $error("control reserved bits not zero");

	property p_cal_flags;
		@(posedge clk_in) disable iff (rst_in)
		(rd_req && cal_hit) |=> (rdata_q[31] == !REF_PRESENT) && (rdata_q[30] == CAL_SKEW)
			&& (rdata_q[29:24] == 6'h00);
	endproperty
	a_cal_flags: assert property (p_cal_flags)
		else $error("calibration flags wrong");

	property p_cal_read_only;
		@(posedge clk_in) disable iff (rst_in)
		(wr_req && cal_hit) |=> $stable(csr_q) && $stable(reload_q);
	endproperty
	a_cal_read_only: assert property (p_cal_read_only)
		else $error("calibration write changed state");

	property p_rvr_write;
		@(posedge clk_in) disable iff (rst_in)
		rvr_wr |=> (reload_q == $past(req_in.wdata[23:0]));
	endproperty
	a_rvr_write: assert property (p_rvr_write)
		else $error("reload write not stored");

	property p_csr_write;
		@(posedge clk_in) disable iff (rst_in)
		csr_wr |=> (csr_q.enable == $past(req_in.wdata[0]))
			&& (csr_q.tick_en == $past(req_in.wdata[1]));
	endproperty
	a_csr_write: assert property (p_csr_write)
		else $error("control write not stored");

	property p_clk_sel_write;
		@(posedge clk_in) disable iff (rst_in)
		(csr_wr && REF_PRESENT) |=> (csr_q.clk_sel == $past(req_in.wdata[2]));
	endproperty
	a_clk_sel_write: assert property (p_clk_sel_write)
		else $error("clock select write not stored");

	property p_no_pend_disabled;
		@(posedge clk_in) disable iff (rst_in)
		(step && !csr_q.tick_en) |=> !tick_pend_out;
	endproperty
	a_no_pend_disabled: assert property (p_no_pend_disabled)
		else $error("tick pended with event enable clear");

	property p_wrap_hold;
		@(posedge clk_in) disable iff (rst_in)
		(wrap_q && !csr_rd && !cvr_wr) |=> wrap_q;
	endproperty
	a_wrap_hold: assert property (p_wrap_hold)
		else $error("wrap flag lost without a clear");

	property p_wrap_cause;
		@(posedge clk_in) disable iff (rst_in)
		$rose(wrap_q) |-> ($past(cnt_q) == `STDC_CNT_ONE) && cnt_zero;
	endproperty
	a_wrap_cause: assert property (p_wrap_cause)
		else $error("wrap flag set without a one-to-zero step");

	property p_ref_edge_count;
		@(posedge clk_in) disable iff (rst_in)
		(REF_PRESENT && csr_q.enable && !debug_halt_in && !csr_q.clk_sel && ref_rise
			&& !cvr_wr && !cnt_zero) |=> (cnt_q == $past(cnt_q) - `STDC_CNT_ONE);
	endproperty
	a_ref_edge_count: assert property (p_ref_edge_count)
		else $error("reference edge did not step the counter");

endmodule

// File: tb/stdc_top_bench.sv
// Self-checking bench for the tick down-counter, driven through its register request port
`timescale 1ns/1ps
module stdc_top_bench;
	// ==========================================================
	// Addresses and expected constants
	localparam logic [31:0] CSR = 32'hE000E010;
	localparam logic [31:0] RVR = 32'hE000E014;
	localparam logic [31:0] CVR = 32'hE000E018;
	localparam logic [31:0] CAL = 32'hE000E01C;
	localparam logic [31:0] HOLE = 32'hE000E020;
	// Ten milliseconds of the 20 MHz core clock, minus one; reference present, value exact
	localparam logic [31:0] CAL_EXP = 32'h00000000 | 32'(200000 - 1);
	localparam int LIMIT = 3000;

	logic clk_in;
	logic rst_in;
	logic ref_clk_in;
	logic debug_halt_in;
	stdc_pkg::stdc_req_t req_in;
	logic [31:0] rdata_out;
	logic rvalid_out;
	logic tick_pend_out;
	logic [31:0] nr_rdata;
	logic nr_rvalid;
	int num_errors;
	int cmp_count;
	int cyc;
	int pend_cnt;
	logic pend_prev;

	initial begin
		clk_in = 1'h0;
		forever #25 clk_in = ~clk_in;
	end

	stdc_top stdc_top_inst (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.req_in(req_in),
		.ref_clk_in(ref_clk_in),
		.debug_halt_in(debug_halt_in),
		.rdata_out(rdata_out),
		.rvalid_out(rvalid_out),
		.tick_pend_out(tick_pend_out)
	);

	// Second copy built without a reference clock, fed the same requests
	stdc_top #(
		.REF_PRESENT(1'h0)
	) stdc_top_no_reference_clock_inst (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.req_in(req_in),
		.ref_clk_in(ref_clk_in),
		.debug_halt_in(debug_halt_in),
		.rdata_out(nr_rdata),
		.rvalid_out(nr_rvalid),
		.tick_pend_out()
	);

	// ==========================================================
	// Closing report
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask

	// ==========================================================
	// Pend pulse monitor and hang guard
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (tick_pend_out === 1'h1) begin
			pend_cnt <= pend_cnt + 1;
		end
		if (tick_pend_out === 1'h1 && pend_prev === 1'h1) begin
			chk("pend pulse width", 32'h00000001, 32'h00000002);
		end
		pend_prev <= tick_pend_out;
		if (cyc == LIMIT) begin
			$display("CHECK FAILED timeout expected %0d seen %0d", LIMIT, cyc);
			num_errors++;
			wrap_up();
		end
	end

	// ==========================================================
	// Register access tasks
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_in);
		req_in <= '{1'h1, 1'h1, a, d};
		@(posedge clk_in);
		req_in <= '0;
	endtask

	// Answer is registered: it stands in the cycle after the request edge
	task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
		@(posedge clk_in);
		req_in <= '{1'h1, 1'h0, a, 32'h00000000};
		@(posedge clk_in);
		req_in <= '0;
		#1;
		chk("rvalid", 32'h00000001, {31'h00000000, rvalid_out});
		chk(what, exp, rdata_out);
	endtask

	// Lets exactly k core-clock edges see the core running, then halts it again
	task automatic run(input int k);
		@(posedge clk_in);
		debug_halt_in <= 1'h0;
		repeat (k) @(posedge clk_in);
		debug_halt_in <= 1'h1;
	endtask

	// Rising edges of the reference clock, each held long enough to pass the synchroniser
	task automatic ref_pulses(input int n);
		repeat (n) begin
			repeat (4) @(posedge clk_in);
			ref_clk_in <= 1'h1;
			repeat (4) @(posedge clk_in);
			ref_clk_in <= 1'h0;
		end
		repeat (6) @(posedge clk_in);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst_in = 1'h1;
		ref_clk_in = 1'h0;
		debug_halt_in = 1'h1;
		req_in = '0;
		num_errors = 0;
		cmp_count = 0;
		cyc = 0;
		pend_cnt = 0;
		pend_prev = 1'h0;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'h0;

		rd(CSR, 32'h00000000, "control reset");
		chk("no-reference answer", 32'h00000001, {31'h00000000, nr_rvalid});
		chk("no-reference control", 32'h00000004, nr_rdata);
		rd(CAL, CAL_EXP, "calibration");
		chk("no-reference calibration", 32'h80000000 | CAL_EXP, nr_rdata);
		wr(CAL, 32'h00000000);
		rd(CAL, CAL_EXP, "calibration after write");
		rd(HOLE, 32'h00000000, "unmapped");
		wr(RVR, 32'hFFFFFFFF);
		rd(RVR, 32'h00FFFFFF, "reload width");
		wr(CSR, 32'h00000004);
		rd(CSR, 32'h00000004, "clock select");
		wr(CSR, 32'h00000000);
		rd(CSR, 32'h00000000, "clock select cleared");
		chk("no-reference select kept", 32'h00000004, nr_rdata);
		$display("test registers done");

		wr(RVR, 32'h00000005);
		wr(CVR, 32'h00000123);
		rd(CVR, 32'h00000000, "current cleared");
		wr(CSR, 32'h00000005);
		run(3);
		rd(CVR, 32'h00000003, "load then decrement");
		repeat (4) @(posedge clk_in);
		rd(CVR, 32'h00000003, "frozen in halt");
		run(3);
		rd(CVR, 32'h00000000, "reached zero");
		rd(CSR, 32'h00010005, "wrap set");
		rd(CSR, 32'h00000005, "wrap cleared by read");
		chk("pends without enable", 32'h00000000, 32'(pend_cnt));
		$display("test core count done");

		wr(CSR, 32'h00000007);
		run(6);
		run(3);
		wr(CVR, 32'h00000000);
		rd(CVR, 32'h00000000, "current cleared again");
		rd(CSR, 32'h00000007, "wrap cleared by clear");
		chk("pend count", 32'h00000001, 32'(pend_cnt));
		run(3);
		wr(RVR, 32'h00000000);
		run(10);
		rd(CVR, 32'h00000000, "parked at zero");
		rd(CSR, 32'h00010007, "last wrap");
		chk("pend count parked", 32'h00000002, 32'(pend_cnt));
		$display("test pend and reload zero done");

		wr(RVR, 32'h00000005);
		wr(CVR, 32'h00000000);
		wr(CSR, 32'h00000001);
		@(posedge clk_in);
		debug_halt_in <= 1'h0;
		ref_pulses(3);
		rd(CVR, 32'h00000003, "reference count");
		wr(CSR, 32'h00000000);
		ref_pulses(1);
		rd(CVR, 32'h00000003, "disabled");
		debug_halt_in <= 1'h1;
		$display("test reference clock done");
		wrap_up();
	end
endmodule
